// [logic/fan_ctl_pkg.sv]
// constants, types and register map of the fan mode and drive control block
package fan_ctl_pkg;

  localparam logic [7:0]  REG_CONFIG      = 8'h00;
  localparam logic [7:0]  REG_DRIVE       = 8'h04;
  localparam logic [7:0]  REG_SPEED       = 8'h08;
  localparam logic [7:0]  REG_CLKSEL      = 8'h0c;
  localparam logic [7:0]  REG_STATUS      = 8'h10;
  localparam logic [7:0]  REG_COUNT0      = 8'h14;
  localparam logic [7:0]  REG_COUNT3      = 8'h20;

  localparam int          CFG_MODE_LSB    = 4;
  localparam int          CFG_CLASS_BIT   = 3;
  localparam logic [7:0]  CONFIG_RESET    = 8'h00;
  localparam logic [7:0]  DRIVE_RESET     = 8'h00;
  localparam logic [7:0]  SPEED_RESET     = 8'h00;
  localparam logic [7:0]  LOOP_RESET      = 8'h00;

  localparam logic [1:0]  MODE_FULL_ON    = 2'h0;
  localparam logic [1:0]  MODE_FULL_OFF   = 2'h1;
  localparam logic [1:0]  MODE_CLOSED     = 2'h2;
  localparam logic [1:0]  MODE_OPEN       = 2'h3;

  localparam logic [7:0]  CODE_MAX_VOLT   = 8'h00;
  localparam logic [7:0]  CODE_NO_VOLT    = 8'hff;
  localparam logic [7:0]  COUNT_SAT       = 8'hff;
  localparam int          CODE_SCALE      = 256;
  localparam int          DRIVE_LIMIT_5V  = 76;
  localparam int          DRIVE_LIMIT_12V = 180;

  localparam int          CLK_HZ          = 40_000_000;
  localparam int          INT_OSC_HZ      = 254_000;
  localparam int          EXT_MIN_HZ      = 50_000;
  localparam int          EXT_MAX_HZ      = 500_000;
  localparam logic [7:0]  HALF_DIV        = 8'(CLK_HZ / (2 * INT_OSC_HZ));
  localparam int          COUNT_TICKS_DEF = 254_000;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACK  = 2'b10
  } apb_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [7:0] code;
    logic       fullOn;
    logic       off;
    logic       class12v;
    logic       threshHigh;
  } fan_out_type;

  typedef struct packed {
    apb_state_type  apbState;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    logic [7:0]     cfg;
    logic [7:0]     drive;
    logic [7:0]     speed;
    logic           clkSel;
    logic           fullOnS1;
    logic           fullOnS2;
    logic [3:0]     tachS1;
    logic [3:0]     tachS2;
    logic [3:0]     tachS3;
    logic           extS1;
    logic           extS2;
    logic           extS3;
    logic [7:0]     divCnt;
    logic           intClk;
    logic [19:0]    tickCnt;
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] cntReg;
    logic [7:0]     loopCode;
    fan_out_type    fan;
  } state_type;

endpackage

// [logic/fan_mode_drive_ctl.sv]
// fan mode selection, drive code control, pulse counting and apb registers
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - mode field 00 gives software full-on, maximum fan voltage.
// - mode field 01 gives full-off, no drive voltage, fan stops.
// - mode field 11 gives open loop, drive only from host code.
// - mode field 10 gives closed loop, regulating toward host speed value.
// - config bit 3 picks 5V or 12V fan and pulse_count_register threshold.
// - hardware full-on input forces full-on over every mode.
// - host writes 8-bit drive code; open loop drives fan from it.
// - drive code acts inversely on voltage, scaled by code over 256.
// - timing clock is internal or a shared external 50-500 kHz clock.
// - each pulse counter is 8 bits and saturates at 255.
module fan_mode_drive_ctl
  import fan_ctl_pkg::*;
#(
  parameter int COUNT_TICKS = COUNT_TICKS_DEF
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire apb_req_type apbReq,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hwFullOnPin,
  input  wire logic [3:0]  tachPin,
  input  wire logic        extClkPin,
  output logic             timeClkOut,
  output fan_out_type      fanCtl
);

  localparam logic [19:0] LAST_TICK = 20'(COUNT_TICKS - 1);

  state_type   s;
  state_type   next_s;
  logic        intTick;
  logic        extTick;
  logic        tick;
  logic        intervalEnd;
  logic        wrCommit;
  logic [31:0] rdData;
  logic [1:0]  mode;

  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= REG_COUNT3);
  endfunction

  function automatic logic [7:0] satInc(input logic [7:0] v);
    return (v == COUNT_SAT) ? COUNT_SAT : v + 8'h01;
  endfunction

  function automatic logic rise(input logic now, input logic old);
    return now & ~old;
  endfunction

  always_comb begin
    next_s = s;
    // first sync stage feeds only the second
    next_s.fullOnS1 = hwFullOnPin;
    next_s.fullOnS2 = s.fullOnS1;
    next_s.tachS1   = tachPin;
    next_s.tachS2   = s.tachS1;
    next_s.tachS3   = s.tachS2;
    next_s.extS1    = extClkPin;
    next_s.extS2    = s.extS1;
    next_s.extS3    = s.extS2;

    intTick = 1'b0;
    if (s.divCnt == HALF_DIV - 8'h01) begin
      next_s.divCnt = 8'h00;
      next_s.intClk = ~s.intClk;
      intTick       = ~s.intClk;
    end else begin
      next_s.divCnt = s.divCnt + 8'h01;
    end
    extTick     = rise(s.extS2, s.extS3);
    tick        = s.clkSel ? extTick : intTick;
    intervalEnd = tick && (s.tickCnt == LAST_TICK);
    if (tick) begin
      next_s.tickCnt = intervalEnd ? 20'h0 : s.tickCnt + 20'h1;
    end

    for (int i = 0; i < 4; i++) begin
      if (intervalEnd) begin
        next_s.cntReg[i] = s.cnt[i];
        next_s.cnt[i]    = rise(s.tachS2[i], s.tachS3[i]) ? 8'h01 : 8'h00;
      end else if (rise(s.tachS2[i], s.tachS3[i])) begin
        next_s.cnt[i] = satInc(s.cnt[i]);
      end
    end

    // too few pulses means lower code, i.e. more voltage
    if (intervalEnd && s.cfg[CFG_MODE_LSB +: 2] == MODE_CLOSED) begin
      if (s.cnt[0] < s.speed && s.loopCode != CODE_MAX_VOLT) begin
        next_s.loopCode = s.loopCode - 8'h01;
      end else if (s.cnt[0] > s.speed && s.loopCode != CODE_NO_VOLT) begin
        next_s.loopCode = s.loopCode + 8'h01;
      end
    end

    case (apbReq.paddr)
      REG_CONFIG: rdData = {24'h0, s.cfg};
      REG_DRIVE:  rdData = {24'h0, s.drive};
      REG_SPEED:  rdData = {24'h0, s.speed};
      REG_CLKSEL: rdData = {31'h0, s.clkSel};
      REG_STATUS: rdData = {16'h0, s.loopCode, 4'h0, s.fullOnS2, s.fan.fullOn,
                            s.fan.off, s.fan.class12v};
      default: begin
        rdData = 32'h0;
        for (int i = 0; i < 4; i++) begin
          if (apbReq.paddr == REG_COUNT0 + 8'(4 * i)) begin
            rdData = {24'h0, s.cntReg[i]};
          end
        end
      end
    endcase

    wrCommit = apbReq.psel && apbReq.penable && apbReq.pwrite && s.pready &&
               isMapped(apbReq.paddr);
    case (s.apbState)
      APB_IDLE: begin
        if (apbReq.psel && apbReq.penable) begin
          next_s.apbState = APB_ACK;
          next_s.pready   = 1'b1;
          next_s.pslverr  = ~isMapped(apbReq.paddr);
          next_s.prdata   = apbReq.pwrite ? 32'h0 : rdData;
        end
      end
      APB_ACK: begin
        next_s.apbState = APB_IDLE;
        next_s.pready   = 1'b0;
        next_s.pslverr  = 1'b0;
        next_s.prdata   = 32'h0;
      end
      default: begin
        next_s.apbState = APB_IDLE;
        next_s.pready   = 1'b0;
        next_s.pslverr  = 1'b0;
      end
    endcase
    if (wrCommit) begin
      case (apbReq.paddr)
        REG_CONFIG: next_s.cfg    = apbReq.pwdata[7:0];
        REG_DRIVE:  next_s.drive  = apbReq.pwdata[7:0];
        REG_SPEED:  next_s.speed  = apbReq.pwdata[7:0];
        REG_CLKSEL: next_s.clkSel = apbReq.pwdata[0];
        default:    next_s.clkSel = s.clkSel;
      endcase
    end

    // built from the next config so a write shows one edge later, no step between
    mode                  = next_s.cfg[CFG_MODE_LSB +: 2];
    next_s.fan.class12v   = next_s.cfg[CFG_CLASS_BIT];
    next_s.fan.threshHigh = next_s.cfg[CFG_CLASS_BIT];
    next_s.fan.fullOn     = 1'b0;
    next_s.fan.off        = 1'b0;
    if (next_s.fullOnS2) begin
      next_s.fan.fullOn = 1'b1;
      next_s.fan.code   = CODE_MAX_VOLT;
    end else begin
      case (mode)
        MODE_FULL_ON: begin
          next_s.fan.fullOn = 1'b1;
          next_s.fan.code   = CODE_MAX_VOLT;
        end
        MODE_FULL_OFF: begin
          next_s.fan.off  = 1'b1;
          next_s.fan.code = CODE_NO_VOLT;
        end
        MODE_CLOSED: next_s.fan.code = next_s.loopCode;
        MODE_OPEN:   next_s.fan.code = next_s.drive;
        default:     next_s.fan.code = CODE_NO_VOLT;
      endcase
    end
  end

  // ce low freezes the apb handshake as well; a waiting master waits longer, but a write acked at an edge with ce low is not stored
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s               <= '0;
      s.apbState      <= APB_IDLE;
      s.cfg           <= CONFIG_RESET;
      s.drive         <= DRIVE_RESET;
      s.speed         <= SPEED_RESET;
      s.loopCode      <= LOOP_RESET;
      s.fan.fullOn    <= 1'b1;
      s.fan.code      <= CODE_MAX_VOLT;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata     = s.prdata;
  assign pready     = s.pready;
  assign pslverr    = s.pslverr;
  assign timeClkOut = s.intClk;
  assign fanCtl     = s.fan;

  property p_fullon_sw;
    @(posedge mclk) disable iff (!reset_n)
    (!s.fullOnS2 && s.cfg[5:4] == MODE_FULL_ON) |-> (fanCtl.fullOn && fanCtl.code == 8'h00);
  endproperty
  a_fullon_sw: assert property (p_fullon_sw) else $error("full-on mode not applied");

  property p_full_off;
    @(posedge mclk) disable iff (!reset_n)
    (!s.fullOnS2 && s.cfg[5:4] == MODE_FULL_OFF)
      |-> (fanCtl.off && !fanCtl.fullOn && fanCtl.code == CODE_NO_VOLT);
  endproperty
  a_full_off: assert property (p_full_off) else $error("full-off mode not applied");

  property p_open_loop;
    @(posedge mclk) disable iff (!reset_n)
    (!s.fullOnS2 && s.cfg[5:4] == MODE_OPEN) |-> (fanCtl.code == s.drive && !fanCtl.off);
  endproperty
  a_open_loop: assert property (p_open_loop) else $error("open loop code mismatch");

  property p_closed_loop;
    @(posedge mclk) disable iff (!reset_n)
    (!s.fullOnS2 && s.cfg[5:4] == MODE_CLOSED) |-> (fanCtl.code == s.loopCode);
  endproperty
  a_closed_loop: assert property (p_closed_loop) else $error("closed loop code mismatch");

  property p_class;
    @(posedge mclk) disable iff (!reset_n)
    (fanCtl.class12v == s.cfg[3]) && (fanCtl.threshHigh == s.cfg[3]);
  endproperty
  a_class: assert property (p_class) else $error("fan class select wrong");

  property p_hw_fullon;
    @(posedge mclk) disable iff (!reset_n)
    s.fullOnS2 |-> (fanCtl.fullOn && !fanCtl.off && fanCtl.code == 8'h00);
  endproperty
  a_hw_fullon: assert property (p_hw_fullon) else $error("hardware full-on ignored");

  property p_drive_write;
    @(posedge mclk) disable iff (!reset_n)
    (ce && wrCommit && apbReq.paddr == REG_DRIVE && s.cfg[5:4] == MODE_OPEN &&
     !s.fullOnS1 && !s.fullOnS2)
      |=> (fanCtl.code == $past(apbReq.pwdata[7:0]));
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("drive write not applied");

  property p_saturate;
    @(posedge mclk) disable iff (!reset_n)
    (ce && s.cnt[0] == 8'hff && !intervalEnd) |=> (s.cnt[0] == 8'hff);
  endproperty
  a_saturate: assert property (p_saturate) else $error("pulse counter wrapped");

  property p_ext_tick;
    @(posedge mclk) disable iff (!reset_n)
    (s.clkSel && tick) |-> (s.extS2 && !s.extS3);
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("tick not from external clock");

  property p_mode_write;
    @(posedge mclk) disable iff (!reset_n)
    (ce && wrCommit && apbReq.paddr == REG_CONFIG && apbReq.pwdata[5:4] == MODE_FULL_OFF)
      |=> (fanCtl.off || fanCtl.fullOn);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write late");

  property p_class_write;
    @(posedge mclk) disable iff (!reset_n)
    (ce && wrCommit && apbReq.paddr == REG_CONFIG)
      |=> (fanCtl.class12v == $past(apbReq.pwdata[CFG_CLASS_BIT]));
  endproperty
  a_class_write: assert property (p_class_write) else $error("class write late");

  // one step per interval keeps the loop slow against the fan's inertia
  property p_loop_step;
    @(posedge mclk) disable iff (!reset_n)
    (ce && intervalEnd && s.cfg[CFG_MODE_LSB +: 2] == MODE_CLOSED && s.cnt[0] > s.speed &&
     s.loopCode != CODE_NO_VOLT) |=> (s.loopCode == $past(s.loopCode) + 8'h01);
  endproperty
  a_loop_step: assert property (p_loop_step) else $error("loop code did not step");

  property p_count_latch;
    @(posedge mclk) disable iff (!reset_n)
    (ce && intervalEnd) |=> (s.cntReg == $past(s.cnt));
  endproperty
  a_count_latch: assert property (p_count_latch) else $error("counts not latched");

  property p_fullon_code;
    @(posedge mclk) disable iff (!reset_n)
    fanCtl.fullOn |-> (fanCtl.code == CODE_MAX_VOLT && !fanCtl.off);
  endproperty
  a_fullon_code: assert property (p_fullon_code) else $error("full-on code wrong");

  c_open_write: cover property (@(posedge mclk) disable iff (!reset_n)
    wrCommit && apbReq.paddr == REG_DRIVE && s.cfg[5:4] == MODE_OPEN);
  c_hw_override: cover property (@(posedge mclk) disable iff (!reset_n)
    s.fullOnS2 && s.cfg[5:4] == MODE_FULL_OFF);
  c_interval: cover property (@(posedge mclk) disable iff (!reset_n)
    intervalEnd && s.cfg[5:4] == MODE_CLOSED);
  c_ext_interval: cover property (@(posedge mclk) disable iff (!reset_n)
    intervalEnd && s.clkSel);
  c_count_sat: cover property (@(posedge mclk) disable iff (!reset_n)
    intervalEnd && s.cnt[0] == COUNT_SAT);

endmodule

`default_nettype wire

// [tb/fan_pulse_count_register_model.sv]
// fan tachometer and shared timing clock model
`timescale 1ns/1ps
`default_nettype none
module fan_pulse_count_register_model (
  input  wire logic       mclk,
  input  wire logic       run,
  output logic [3:0]      pulse_count_register,
  output logic            extClk
);
  logic [7:0] div = 8'h00;
  initial pulse_count_register = 4'h0;
  initial extClk = 1'b0;
  // 40 MHz / 160 = 250 kHz, inside the shared clock range
  always @(posedge mclk) begin
    div <= (div == 8'h4f) ? 8'h00 : div + 8'h01;
    if (div == 8'h4f) extClk <= ~extClk;
    // lane 0 overruns the 8-bit count, lanes 1-3 stay well below it
    if (run) begin
      pulse_count_register[0] <= ~pulse_count_register[0];
      if (div[2:0] == 3'h0) pulse_count_register[3:1] <= ~pulse_count_register[3:1];
    end
  end
endmodule
`default_nettype wire

// [tb/fan_mode_and_drive_control_tb.sv]
// self-checking bench of the fan mode and drive control block
`timescale 1ns/1ps
`default_nettype none
module fan_mode_and_drive_control_tb;
  import fan_ctl_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce = 1'b0;
  logic        hwFullOnPin = 1'b0;
  logic        tachRun = 1'b0;
  apb_req_type apbReq = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timeClkOut;
  fan_out_type fanCtl;
  logic [3:0]  tachPin;
  logic        extClk;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          check_count = 0;

  always #12.5 mclk = ~mclk;

  fan_mode_drive_ctl #(.COUNT_TICKS(4)) u_fan_mode_drive_ctl (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .ce          (ce),
    .apbReq      (apbReq),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .hwFullOnPin (hwFullOnPin),
    .tachPin     (tachPin),
    .extClkPin   (extClk),
    .timeClkOut  (timeClkOut),
    .fanCtl      (fanCtl)
  );

  fan_pulse_count_register_model u_fan_pulse_count_register_model (
    .mclk   (mclk),
    .run    (tachRun),
    .pulse_count_register   (tachPin),
    .extClk (extClk)
  );

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // held unchanged until pready is sampled high, released at that edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= addr;
    apbReq.pwdata <= wd;
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  // outputs must have settled by the second edge after the write edge
  task automatic fan_chk(input logic [7:0] code, input logic on, input logic off,
                         input logic cls);
    repeat (2) @(posedge mclk);
    #1;
    chk("code", {24'h0, code}, {24'h0, fanCtl.code});
    chk("fullOn", {31'h0, on}, {31'h0, fanCtl.fullOn});
    chk("off", {31'h0, off}, {31'h0, fanCtl.off});
    chk("class12v", {31'h0, cls}, {31'h0, fanCtl.class12v});
    chk("threshHigh", {31'h0, cls}, {31'h0, fanCtl.threshHigh});
  endtask

  // half period of the internal timing clock output, in mclk edges
  task automatic clk_chk;
    logic last;
    int   gap;
    last = timeClkOut;
    gap = 0;
    while (timeClkOut === last && gap < 400) begin
      @(posedge mclk);
      gap++;
    end
    last = timeClkOut;
    gap = 0;
    while (timeClkOut === last && gap < 400) begin
      @(posedge mclk);
      gap++;
    end
    chk("timeClk half", {24'h0, HALF_DIV}, 32'(gap));
  endtask

  initial begin
    #500_000;
    error_cnt++;
    give_verdict;
  end

  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    ce <= 1'b1;
    fan_chk(8'h00, 1'b1, 1'b0, 1'b0);
    clk_chk;
    apb(1'b0, REG_CONFIG, 32'h0);
    chk("config", 32'h0, rd);
    chk("config err", 32'h0, {31'h0, err});
    apb(1'b1, REG_DRIVE, 32'h4c);
    apb(1'b1, REG_CONFIG, 32'h38);
    fan_chk(8'h4c, 1'b0, 1'b0, 1'b1);
    apb(1'b1, REG_DRIVE, 32'hb4);
    fan_chk(8'hb4, 1'b0, 1'b0, 1'b1);
    // clock enable low must hold the outputs although full-on is raised
    @(posedge mclk);
    ce <= 1'b0;
    hwFullOnPin <= 1'b1;
    repeat (4) @(posedge mclk);
    fan_chk(8'hb4, 1'b0, 1'b0, 1'b1);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    fan_chk(8'h00, 1'b1, 1'b0, 1'b1);
    apb(1'b1, REG_CONFIG, 32'h18);
    fan_chk(8'h00, 1'b1, 1'b0, 1'b1);
    @(posedge mclk);
    hwFullOnPin <= 1'b0;
    repeat (2) @(posedge mclk);
    fan_chk(8'hff, 1'b0, 1'b1, 1'b1);
    apb(1'b1, REG_CONFIG, 32'h00);
    fan_chk(8'h00, 1'b1, 1'b0, 1'b0);
    // target of zero pulses makes the loop step the code up each interval
    apb(1'b1, REG_SPEED, 32'h0);
    apb(1'b1, REG_CONFIG, 32'h20);
    tachRun <= 1'b1;
    repeat (2000) @(posedge mclk);
    chk("loop", 32'h1, {31'h0, fanCtl.code != 8'h00 && !fanCtl.off && !fanCtl.fullOn});
    apb(1'b0, REG_COUNT0, 32'h0);
    chk("count0", {24'h0, COUNT_SAT}, rd);
    apb(1'b0, REG_COUNT0 + 8'h04, 32'h0);
    // internal tick every 156 edges: 624 per interval, one lane rise per 16 edges
    chk("count1", 32'h27, rd);
    apb(1'b1, REG_COUNT0, 32'h0);
    apb(1'b0, REG_COUNT0, 32'h0);
    chk("count0 ro", {24'h0, COUNT_SAT}, rd);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped rd", 32'h0, rd);
    apb(1'b1, REG_CLKSEL, 32'h1);
    apb(1'b0, REG_CLKSEL, 32'h0);
    chk("clksel", 32'h1, rd);
    // shared clock rises every 160 edges, so a full interval now holds 40 lane rises
    repeat (1500) @(posedge mclk);
    apb(1'b0, REG_COUNT0 + 8'h04, 32'h0);
    chk("count1 ext", 32'h28, rd);
    give_verdict;
  end
endmodule
`default_nettype wire
